/* File: rtl/user_timing4_pkg.sv */
package user_timing4_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int LINE_W = 15;
    localparam int PIXEL_W = 16;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_H_START = 8'h66;
    localparam logic [7:0] IDX_H_STOP = 8'h67;
    localparam logic [7:0] IDX_V_START = 8'h68;
    localparam logic [7:0] IDX_V_STOP = 8'h69;
    localparam logic [7:0] IDX_COMBINE = 8'h6a;
    localparam logic [7:0] IDX_STATUS = 8'h6b;

    // field positions of the combine register
    localparam int BIT_POLARITY = 3;
    localparam int BIT_AND = 2;
    localparam int BIT_OR = 1;
    localparam int BIT_XOR = 0;
    localparam int COMBINE_W = 4;

    // field positions of the status register
    localparam int BIT_ST_H = 0;
    localparam int BIT_ST_V = 1;
    localparam int BIT_ST_RAW = 2;

    // values after reset
    localparam logic [PIXEL_W-1:0] RST_H_START = 16'h0000;
    localparam logic [PIXEL_W-1:0] RST_H_STOP = 16'h0000;
    localparam logic [LINE_W-1:0] RST_V_START = 15'h0000;
    localparam logic [LINE_W-1:0] RST_V_STOP = 15'h0000;
    localparam logic [COMBINE_W-1:0] RST_COMBINE = 4'h8;
    localparam logic RST_OUTPUT = 1'b1;
    localparam logic [DATA_W-1:0] RST_RDATA = 16'h0000;

    typedef struct packed {
        logic polarity;
        logic op_and;
        logic op_or;
        logic op_xor;
    } combine_ctl_t;

    typedef struct packed {
        logic raw;
        logic v_active;
        logic h_active;
    } window_status_t;

endpackage : user_timing4_pkg

/* File: rtl/window_compare.sv */
module window_compare #(
    parameter int W = 16
) (
    input wire logic [W-1:0] start_in,
    input wire logic [W-1:0] stop_in,
    input wire logic [W-1:0] count_in,
    output logic active_out
);

    // active from start up to, not including, stop
    assign active_out = (count_in >= start_in) && (count_in < stop_in);

endmodule : window_compare

/* File: rtl/user_timing_signal_vertical_combiner.sv */
// Notes on behaviour
// - the 15-bit start-line field sets where the vertical window begins.
// - the 15-bit end-line field sets where the vertical window ends.
// - polarity bit 3 resets to 1 for active-low output, 0 gives active high.
// - with AND bit 2 set the output is active only when both windows are.
// - with AND set the OR and XOR bits have no effect.
// - with OR bit 1 set and AND clear either window makes the output active.
// - with OR set the XOR bit has no effect.
// - with only XOR bit 0 set exactly one active window drives the output.
// - the horizontal window spans 16-bit start and stop pixel positions.
module user_timing_signal_vertical_combiner
    import user_timing4_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    input wire logic [PIXEL_W-1:0] pixel_count_in,
    input wire logic [LINE_W-1:0] line_count_in,
    output logic combined_user_timing_output_out
);

    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [7:0] idx);
        addr_hit = (addr == {idx, 2'b00});
    endfunction : addr_hit

    logic [PIXEL_W-1:0] user_hsync4_start_pixel;
    logic [PIXEL_W-1:0] user_hsync4_end_pixel;
    logic [LINE_W-1:0] user_vsync4_start_line;
    logic [LINE_W-1:0] user_vsync4_end_line;
    combine_ctl_t user_signal4_combine_and_level;

    logic [PIXEL_W-1:0] h_start_live;
    logic [PIXEL_W-1:0] h_stop_live;
    logic [LINE_W-1:0] v_start_live;
    logic [LINE_W-1:0] v_stop_live;

    logic user_signal_horizontal_window;
    logic user_signal_vertical_window;
    logic combined_raw;
    logic next_output;
    window_status_t status;

    // write enables, window combinations and held read data
    logic wr_h_start;
    logic wr_h_stop;
    logic wr_v_start;
    logic wr_v_stop;
    logic wr_combine;
    logic both_active;
    logic either_active;
    logic one_active;
    logic [DATA_W-1:0] next_rdata_hold;

    // address decode
    wire hit_h_start = addr_hit(reg_addr_in, IDX_H_START);
    wire hit_h_stop = addr_hit(reg_addr_in, IDX_H_STOP);
    wire hit_v_start = addr_hit(reg_addr_in, IDX_V_START);
    wire hit_v_stop = addr_hit(reg_addr_in, IDX_V_STOP);
    wire hit_combine = addr_hit(reg_addr_in, IDX_COMBINE);
    wire hit_status = addr_hit(reg_addr_in, IDX_STATUS);
    wire line_boundary = (pixel_count_in == {PIXEL_W{1'b0}});

    // write enables; reserved bits are dropped
    assign wr_h_start = reg_wr_in && hit_h_start;
    assign wr_h_stop = reg_wr_in && hit_h_stop;
    assign wr_v_start = reg_wr_in && hit_v_start;
    assign wr_v_stop = reg_wr_in && hit_v_stop;
    assign wr_combine = reg_wr_in && hit_combine;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            user_hsync4_start_pixel <= RST_H_START;
        end else if (wr_h_start) begin
            user_hsync4_start_pixel <= reg_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            user_hsync4_end_pixel <= RST_H_STOP;
        end else if (wr_h_stop) begin
            user_hsync4_end_pixel <= reg_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            user_vsync4_start_line <= RST_V_START;
        end else if (wr_v_start) begin
            user_vsync4_start_line <= reg_wdata_in[LINE_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            user_vsync4_end_line <= RST_V_STOP;
        end else if (wr_v_stop) begin
            user_vsync4_end_line <= reg_wdata_in[LINE_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            user_signal4_combine_and_level <= RST_COMBINE;
        end else if (wr_combine) begin
            user_signal4_combine_and_level <=
                reg_wdata_in[COMBINE_W-1:0];
        end
    end

    // horizontal limits change only at the start of a line
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            h_start_live <= RST_H_START;
            h_stop_live <= RST_H_STOP;
        end else if (line_boundary) begin
            h_start_live <= user_hsync4_start_pixel;
            h_stop_live <= user_hsync4_end_pixel;
        end
    end

    // vertical limits likewise, so a window never moves mid-line
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            v_start_live <= RST_V_START;
            v_stop_live <= RST_V_STOP;
        end else if (line_boundary) begin
            v_start_live <= user_vsync4_start_line;
            v_stop_live <= user_vsync4_end_line;
        end
    end

    // horizontal window against the pixel counter
    window_compare #(
        .W(PIXEL_W)
    ) u_h_window (
        .start_in(h_start_live),
        .stop_in(h_stop_live),
        .count_in(pixel_count_in),
        .active_out(user_signal_horizontal_window)
    );

    // vertical window against the line counter
    window_compare #(
        .W(LINE_W)
    ) u_v_window (
        .start_in(v_start_live),
        .stop_in(v_stop_live),
        .count_in(line_count_in),
        .active_out(user_signal_vertical_window)
    );

    // the three candidate combinations of the two windows
    assign both_active = user_signal_horizontal_window &
        user_signal_vertical_window;
    assign either_active = user_signal_horizontal_window |
        user_signal_vertical_window;
    assign one_active = user_signal_horizontal_window ^
        user_signal_vertical_window;

    // fixed priority: and over or over xor; nothing selected is inactive
    assign combined_raw =
        user_signal4_combine_and_level.op_and ? both_active :
        user_signal4_combine_and_level.op_or ? either_active :
        user_signal4_combine_and_level.op_xor ? one_active :
        1'b0;

    assign next_output = user_signal4_combine_and_level.polarity ?
        ~combined_raw : combined_raw;

    // final level registered so downstream never sees a glitch
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            combined_user_timing_output_out <= RST_OUTPUT;
        end else begin
            combined_user_timing_output_out <= next_output;
        end
    end

    // live window state for software
    assign status.raw = combined_raw;
    assign status.v_active = user_signal_vertical_window;
    assign status.h_active = user_signal_horizontal_window;

    // read mux; reserved and unmapped bits read zero
    wire [DATA_W-1:0] rd_h_start = user_hsync4_start_pixel;
    wire [DATA_W-1:0] rd_h_stop = user_hsync4_end_pixel;
    wire [DATA_W-1:0] rd_v_start = {1'b0, user_vsync4_start_line};
    wire [DATA_W-1:0] rd_v_stop = {1'b0, user_vsync4_end_line};
    wire [DATA_W-1:0] rd_combine = {12'h000,
                                    user_signal4_combine_and_level};
    wire [DATA_W-1:0] rd_status = {13'h0000, status};
    wire [DATA_W-1:0] next_rdata =
        hit_h_start ? rd_h_start :
        hit_h_stop ? rd_h_stop :
        hit_v_start ? rd_v_start :
        hit_v_stop ? rd_v_stop :
        hit_combine ? rd_combine :
        hit_status ? rd_status :
        RST_RDATA;

    // read data stand one cycle after the strobe, zero otherwise
    assign next_rdata_hold =
        reg_rd_in ? next_rdata : RST_RDATA;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= RST_RDATA;
        end else begin
            reg_rdata_out <= next_rdata_hold;
        end
    end

endmodule : user_timing_signal_vertical_combiner

/* File: testbench/user_timing4_checker.sv */
module user_timing4_checker
    import user_timing4_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [DATA_W-1:0] reg_rdata_out,
    input wire logic combined_user_timing_output_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    logic [3:0] cmb;
    wire st = reg_rd_in && reg_addr_in == 10'h1ac;
    wire [15:0] q = reg_rdata_out;
    wire o = combined_user_timing_output_out;
    always_ff @(posedge sys_clk_in) begin
        if (rst_in)
            cmb <= RST_COMBINE;
        else if (reg_wr_in && reg_addr_in == 10'h1a8)
            cmb <= reg_wdata_in[3:0];
    end
    a_reset_level: assert property (disable iff (1'b0)
        rst_in |=> o) else $error("output not idle after reset");
    a_comb_reserved: assert property (
        reg_rd_in && reg_addr_in == 10'h1a8 |=> q[15:4] == 12'h000)
        else $error("reserved combine bits read nonzero");
    a_line_bit15: assert property (
        reg_rd_in && reg_addr_in[9:3] == 7'h34 |=> !q[15])
        else $error("line register bit 15 read nonzero");
    a_idle_level: assert property (
        cmb[2:0] == 3'h0 |=> o == $past(cmb[3]))
        else $error("idle output level wrong");
    a_status_level: assert property (st |=> o == (cmb[3] ^ q[2]))
        else $error("output polarity wrong");
    a_and_raw: assert property (st && cmb[2] |=> q[2] == (q[0] & q[1]))
        else $error("and combine wrong");
    a_or_raw: assert property (
        st && cmb[2:1] == 2'h1 |=> q[2] == (q[0] | q[1]))
        else $error("or combine wrong");
    a_xor_raw: assert property (
        st && cmb[2:0] == 3'h1 |=> q[2] == (q[0] ^ q[1]))
        else $error("xor combine wrong");
endmodule : user_timing4_checker
bind user_timing_signal_vertical_combiner user_timing4_checker u_chk (
    .sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .combined_user_timing_output_out);

/* File: testbench/timing_sink.sv */
module timing_sink (
    input wire logic sys_clk_in,
    input wire logic clear_in,
    input wire logic level_in,
    output logic [15:0] active_cnt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // counts cycles the downstream sees the signal high
    always_ff @(posedge sys_clk_in) begin
        if (clear_in)
            active_cnt_out <= 16'h0000;
        else if (level_in)
            active_cnt_out <= active_cnt_out + 16'h0001;
    end
endmodule : timing_sink

/* File: testbench/testbench.sv */
module testbench
    import user_timing4_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, wr = 0, rd = 0, clr = 1, out, os, h, v, r;
    logic [9:0] addr = '0;
    logic [15:0] wd = '0, rdata, px = '0, cnt;
    logic [14:0] ln = '0;
    logic [3:0] ops [8] = '{4'h4, 4'h7, 4'h6, 4'h2, 4'h3, 4'h1, 4'h0, 4'hd};
    int error_cnt = 0, samples_checked = 0;
    always #2 clk = ~clk;
    user_timing_signal_vertical_combiner dut (.sys_clk_in(clk),
        .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wd),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .pixel_count_in(px), .line_count_in(ln),
        .combined_user_timing_output_out(out));
    timing_sink sink (.sys_clk_in(clk), .clear_in(clr), .level_in(out),
        .active_cnt_out(cnt));
    task automatic compare(input logic [15:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare
    task automatic compare_level(input logic got, exp);
        compare({15'h0000, got}, {15'h0000, exp});
    endtask : compare_level
    task automatic wr_reg(input logic [7:0] i, input logic [15:0] d);
        addr <= {i, 2'h0};
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] i, input logic [15:0] e);
        addr <= {i, 2'h0};
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 os = out;
        compare(rdata, e);
        @(posedge clk);
    endtask : rd_reg
    task automatic point(input logic [15:0] p, input logic [14:0] l,
        input logic [2:0] s, input logic o);
        px <= p;
        ln <= l;
        rd_reg(IDX_STATUS, {13'h0000, s});
        compare_level(os, o);
    endtask : point
    task automatic summarize;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    initial begin
        #10000 error_cnt++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        compare_level(out, 1'b1);
        @(posedge clk);
        for (int a = 8'h66; a < 8'h6c; a++) begin
            rd_reg(8'(a), {12'h000, a == 8'h6a, 3'h0});
        end
        rd_reg(8'h70, 16'h0000);
        // limits programmed start below stop, end within field
        wr_reg(IDX_H_STOP, 16'h0005);
        wr_reg(IDX_H_START, 16'h0002);
        wr_reg(IDX_V_STOP, 16'h0006);
        wr_reg(IDX_V_START, 16'h0003);
        rd_reg(IDX_V_START, 16'h0003);
        rd_reg(IDX_V_STOP, 16'h0006);
        rd_reg(IDX_H_STOP, 16'h0005);
        rd_reg(IDX_H_START, 16'h0002);
        foreach (ops[k]) begin
            wr_reg(IDX_COMBINE, {12'h000, ops[k]});
            rd_reg(IDX_COMBINE, {12'h000, ops[k]});
            for (int i = 0; i < 4; i++) begin
                h = !i[0];
                v = !i[1];
                r = ops[k][2] ? h & v :
                    ops[k][1] ? h | v : ops[k][0] & (h ^ v);
                point(i[0] ? 16'h0005 : 16'h0002, i[1] ? 15'h0006 : 15'h0003,
                    {r, v, h}, ops[k][3] ^ r);
            end
        end
        wr_reg(IDX_COMBINE, 16'h0004);
        point(16'h0000, 15'h0004, 3'h2, 1'b0);
        clr <= 1'b0;
        for (int p = 0; p < 10; p++) begin
            px <= 16'(p);
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
        #1;
        compare(cnt, 16'h0003);
        @(posedge clk);
        point(16'h0003, 15'h0004, 3'h7, 1'b1);
        wr_reg(IDX_V_STOP, 16'h0004);
        point(16'h0003, 15'h0004, 3'h7, 1'b1);
        point(16'h0000, 15'h0004, 3'h2, 1'b0);
        point(16'h0003, 15'h0004, 3'h1, 1'b0);
        summarize();
    end
endmodule : testbench
